// ### design/cxl_pkg.sv
// Purpose: shared constants, types and register map for the lane control
// Assumes: 250 MHz device clock, APB slave with 32-bit data
// Notes: all offsets are byte addresses of aligned words
package cxl_pkg;
  localparam int unsigned LANES = 4;
  localparam int unsigned CLK_MHZ = 250;
  // loss-of-signal bounds, in microseconds
  localparam int unsigned LOS_MIN_US = 250;
  localparam int unsigned LOS_MAX_US = 500;
  // fail after more than the minimum, well before the maximum
  localparam int unsigned LOS_FAIL_US = 300;
  localparam int unsigned LOS_FAIL_CYC = LOS_FAIL_US * CLK_MHZ;
  localparam int unsigned LOS_CNT_W = 17;
  // latency budget in bit times and the budget actually used
  localparam int unsigned LAT_LIMIT_BT = 512;
  localparam int unsigned LAT_USED_CYC = 2;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0C;
  // control field positions
  localparam int unsigned CTRL_GDIS = 0;
  localparam int unsigned CTRL_LOOP = 1;
  localparam int unsigned CTRL_FGATE = 2;
  localparam int unsigned CTRL_LDIS = 4;
  // status and event field positions
  localparam int unsigned STAT_SD = 0;
  localparam int unsigned STAT_FLT = 1;
  localparam int unsigned STAT_TXF = 2;
  localparam int unsigned STAT_RXF = 3;
  localparam int unsigned STAT_LSD = 4;
  localparam int unsigned EVT_W = 4;
  localparam logic [7:0] CTRL_RST = 8'h04;
  localparam logic [3:0] TX_IDLE = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  // event bits: signal detect lost, gained, fault rose, fault fell
  localparam int unsigned EVT_SDLOST = 0;
  localparam int unsigned EVT_SDUP = 1;
  localparam int unsigned EVT_FUP = 2;
  localparam int unsigned EVT_FDN = 3;
  typedef struct packed {
    logic [3:0] tx_fault;
    logic [3:0] rx_fault;
  } cxl_fault_s;
  typedef enum logic [1:0] {
    CXL_SD_FAIL,
    CXL_SD_OK
  } cxl_sd_e;
endpackage

// ### design/cxl_lane_ctrl.sv
// Purpose: digital control of a four-lane twinax physical medium sublayer
// Assumes: all inputs synchronous to clk; lane bits sampled per clock
// Notes: two register stages end to end, far below the latency budget
`timescale 1ns/10ps
`default_nettype none
// Contract
// - tx bit n drives tx lane n
// - no polarity inversion either direction
// - detect OK only when all lanes valid
// - no fail before 250us, fail by 500us
// - global disable holds all lanes constant
// - fault gating holds all lanes constant
// - lane disable holds only its lane
// - disables never affect loopback data
// - loopback returns tx data, tx stays on
// - total latency at most 512 bit times
// - fault flag follows any local fault
// - tx fault flag follows tx path fault
// - rx fault flag follows rx path fault
module cxl_lane_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // upper layer data
  input wire logic [3:0] tx_bit,
  output logic [3:0] rx_bit,
  // lane side data and detect
  output logic [3:0] tx_lane,
  input wire logic [3:0] rx_lane,
  input wire logic [3:0] rx_valid,
  // fault sources
  input wire cxl_pkg::cxl_fault_s fault_in,
  // status outputs
  output logic signal_detect,
  output logic fault,
  output logic tx_fault,
  output logic rx_fault,
  output logic irq
);
  import cxl_pkg::*;

  // counts a lane's loss time, saturating at the fail point
  function automatic logic [LOS_CNT_W-1:0] los_next(
    input logic valid, input logic [LOS_CNT_W-1:0] cnt);
    logic [LOS_CNT_W-1:0] lim;
    lim = LOS_CNT_W'(LOS_FAIL_CYC);
    if (valid) begin
      los_next = '0;
    end else if (cnt < lim) begin
      los_next = cnt + 1'b1;
    end else begin
      los_next = cnt;
    end
  endfunction

  // registers
  logic [7:0] ctrl_q; // control word
  logic [3:0] mask_q; // interrupt mask
  logic [3:0] evt_q; // sticky events
  logic [3:0] evt_set; // event pulses this cycle
  logic [3:0] tx_lane_q; // registered lane drive
  logic [3:0] rx_bit_q; // registered upper rx data
  logic [LOS_CNT_W-1:0] los_q [LANES]; // per-lane loss timers
  logic [3:0] lane_lost; // lane timed out
  cxl_sd_e sd_q; // global detect state
  logic sd_d;
  logic flt_q; // previous fault, for edges

  // decoded bus access
  wire logic acc_wr = psel & penable & pwrite;
  wire logic hit_ctrl = paddr == REG_CTRL;
  wire logic hit_stat = paddr == REG_STAT;
  wire logic hit_irq = paddr == REG_IRQ;
  wire logic hit_mask = paddr == REG_MASK;
  wire logic hit_any = hit_ctrl | hit_stat | hit_irq | hit_mask;

  // control fields
  wire logic gdis = ctrl_q[CTRL_GDIS];
  wire logic loop = ctrl_q[CTRL_LOOP];
  wire logic fgate = ctrl_q[CTRL_FGATE];
  wire logic [3:0] ldis = ctrl_q[CTRL_LDIS +: 4];

  // fault aggregation; any lane fault is a local fault
  wire logic txf = |fault_in.tx_fault;
  wire logic rxf = |fault_in.rx_fault;
  wire logic anyf = txf | rxf;

  // a lane is held low by global disable, its own disable, or gated fault;
  // per-lane gating is covered by all_off, so any gated fault silences every lane
  wire logic all_off = gdis | (fgate & anyf);
  wire logic [3:0] lane_off = ldis | (fgate ? fault_in.tx_fault : 4'h0);
  // held level is zero, a constant non-toggling state
  wire logic [3:0] tx_d = all_off ? TX_IDLE : (tx_bit & ~lane_off);
  // loopback picks raw tx bits, before any disable gating
  wire logic [3:0] rx_d = loop ? tx_bit : rx_lane;

  // one stage each way; two cycles total is 25 bit times at 3.125 GBd
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_lane_q <= TX_IDLE;
      rx_bit_q <= TX_IDLE;
    end else begin
      tx_lane_q <= tx_d;
      rx_bit_q <= rx_d;
    end
  end

  // per-lane loss timers on the device clock
  for (genvar i = 0; i < LANES; i++) begin : g_los
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        los_q[i] <= '0;
      end else begin
        los_q[i] <= los_next(rx_valid[i], los_q[i]);
      end
    end
    assign lane_lost[i] = los_q[i] == LOS_CNT_W'(LOS_FAIL_CYC);
  end

  // ok needs every lane valid now; fail once any lane timed out
  always_comb begin
    sd_d = sd_q == CXL_SD_OK;
    case (sd_q)
      CXL_SD_FAIL: sd_d = &rx_valid;
      CXL_SD_OK: sd_d = ~|lane_lost;
      default: sd_d = 1'b0;
    endcase
  end

  // detect state starts at fail
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sd_q <= CXL_SD_FAIL;
    end else begin
      sd_q <= sd_d ? CXL_SD_OK : CXL_SD_FAIL;
    end
  end

  // edge events for the interrupt block
  always_comb begin
    evt_set = 4'h0;
    evt_set[EVT_SDLOST] = (sd_q == CXL_SD_OK) & ~sd_d;
    evt_set[EVT_SDUP] = (sd_q == CXL_SD_FAIL) & sd_d;
    evt_set[EVT_FUP] = anyf & ~flt_q;
    evt_set[EVT_FDN] = ~anyf & flt_q;
  end

  // control and mask writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
      mask_q <= MASK_RST;
    end else if (acc_wr) begin
      if (hit_ctrl) ctrl_q <= pwdata[7:0];
      if (hit_mask) mask_q <= pwdata[3:0];
    end
  end

  // sticky events: write one clears, a new event wins over the clear
  wire logic [3:0] evt_clr = (acc_wr & hit_irq) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_q <= 4'h0;
      flt_q <= 1'b0;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
      flt_q <= anyf;
    end
  end

  // read mux; zero-wait slave, unmapped reads zero with error
  always_comb begin
    prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      prdata[7:0] = ctrl_q;
    end else if (hit_stat) begin
      prdata[STAT_SD] = sd_q == CXL_SD_OK;
      prdata[STAT_FLT] = anyf;
      prdata[STAT_TXF] = txf;
      prdata[STAT_RXF] = rxf;
      prdata[STAT_LSD +: 4] = rx_valid;
    end else if (hit_irq) begin
      prdata[3:0] = evt_q;
    end else if (hit_mask) begin
      prdata[3:0] = mask_q;
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // outputs
  assign tx_lane = tx_lane_q;
  assign rx_bit = rx_bit_q;
  assign signal_detect = sd_q == CXL_SD_OK;
  assign fault = anyf;
  assign tx_fault = txf;
  assign rx_fault = rxf;
  assign irq = |(evt_q & mask_q);

  // assertions
  // an ungated tx bit shows on its own lane one edge later
  AST_TXMAP: assert property (@(posedge clk) disable iff (!rst_b)
    !$past(all_off) && $past(lane_off) == 4'h0 |-> tx_lane == $past(tx_bit))
    else $error("tx lane does not follow tx bit");

  // global disable parks every lane at the idle level
  AST_GDIS: assert property (@(posedge clk) disable iff (!rst_b)
    gdis |=> tx_lane == TX_IDLE)
    else $error("tx not held under global disable");

  // gated fault parks every lane at the idle level
  AST_FGATE: assert property (@(posedge clk) disable iff (!rst_b)
    fgate && anyf |=> tx_lane == TX_IDLE)
    else $error("tx not held under fault");

  // a lane disable holds its own lane low
  AST_LDIS: assert property (@(posedge clk) disable iff (!rst_b)
    !all_off && ldis[0] |=> !tx_lane[0])
    else $error("lane 0 not held by its disable");

  // loopback data comes from the raw tx bits
  AST_LOOP: assert property (@(posedge clk) disable iff (!rst_b)
    loop |=> rx_bit == $past(tx_bit))
    else $error("loopback data lost");

  // outside loopback the rx bits follow the lanes in order
  AST_RXMAP: assert property (@(posedge clk) disable iff (!rst_b)
    !loop |=> rx_bit == $past(rx_lane))
    else $error("rx bit does not follow rx lane");

  // ok is only granted from all four lanes valid together
  AST_SDOK: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(signal_detect) |-> $past(&rx_valid))
    else $error("detect ok without all lanes valid");

  // a fresh loss on lane 0 cannot drop the detect at once
  AST_SDHOLD: assert property (@(posedge clk) disable iff (!rst_b)
    signal_detect && rx_valid[0] == 1'b0 && los_q[0] == '0
      |=> signal_detect[*8])
    else $error("detect failed too early");

  // the overall fault flag is the or of every local fault
  AST_FLT: assert property (@(posedge clk) disable iff (!rst_b)
    fault == (|fault_in.tx_fault | |fault_in.rx_fault))
    else $error("fault flag wrong");

  // an unmasked event raises the interrupt on the next edge
  AST_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
    evt_set[EVT_FUP] && mask_q[EVT_FUP] && !acc_wr |=> irq)
    else $error("masked-in event raised no interrupt");

  // the transmit fault flag covers only the transmit path
  AST_TXFLT: assert property (@(posedge clk) disable iff (!rst_b)
    tx_fault == |fault_in.tx_fault)
    else $error("tx fault flag wrong");

  // the receive fault flag covers only the receive path
  AST_RXFLT: assert property (@(posedge clk) disable iff (!rst_b)
    rx_fault == |fault_in.rx_fault)
    else $error("rx fault flag wrong");

  // loopback alone leaves the transmitters running
  AST_LOOPTX: assert property (@(posedge clk) disable iff (!rst_b)
    loop && !all_off && lane_off == 4'h0 |=> tx_lane == $past(tx_bit))
    else $error("loopback stopped the transmitters");

  // disabling lane 0 leaves lane 1 carrying data
  AST_LDISONE: assert property (@(posedge clk) disable iff (!rst_b)
    !all_off && ldis[0] && !lane_off[1] |=> tx_lane[1] == $past(tx_bit[1]))
    else $error("lane disable touched another lane");

  // global disable and loopback together still loop data
  AST_GDISLOOP: assert property (@(posedge clk) disable iff (!rst_b)
    gdis && loop |=> rx_bit == $past(tx_bit))
    else $error("global disable broke loopback");

  // detect only falls after a lane timer reached the fail point
  AST_SDFAIL: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(signal_detect) |-> $past(|lane_lost))
    else $error("detect failed without a timed-out lane");

  // detect only falls once some lane is past the minimum loss time
  AST_SDMIN: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(signal_detect) |-> $past(|lane_old))
    else $error("detect failed before the minimum loss time");

  // a timed-out lane drops the detect on the next edge
  AST_SDMAX: assert property (@(posedge clk) disable iff (!rst_b)
    signal_detect && |lane_lost |=> !signal_detect)
    else $error("detect held past a timed-out lane");

  // from reset the detect stays at fail until all lanes are valid
  AST_SDSTAY: assert property (@(posedge clk) disable iff (!rst_b)
    !signal_detect && !(&rx_valid) |=> !signal_detect)
    else $error("detect left fail without qualification");

  // a new event is never lost, even against a clear
  AST_STICKY: assert property (@(posedge clk) disable iff (!rst_b)
    evt_set[EVT_FDN] |=> evt_q[EVT_FDN])
    else $error("event bit not captured");

  // a write of one clears a quiet event bit
  AST_IRQCLR: assert property (@(posedge clk) disable iff (!rst_b)
    acc_wr && hit_irq && pwdata[EVT_FUP] && !evt_set[EVT_FUP]
      |=> !evt_q[EVT_FUP])
    else $error("event bit not cleared");

  // with everything masked the interrupt line stays low
  AST_IRQMASK: assert property (@(posedge clk) disable iff (!rst_b)
    mask_q == 4'h0 |-> !irq)
    else $error("interrupt raised while masked");

  // an access to a hole in the map reports an error
  AST_SLVERR: assert property (@(posedge clk) disable iff (!rst_b)
    psel && penable && !hit_any |-> pslverr)
    else $error("unmapped access without error");

  // per-lane timer checks; a lane is old once it has been lost for
  // the minimum hold time, which bounds how early detect may fall
  wire logic [3:0] lane_old; // lost at least the minimum time
  for (genvar k = 0; k < LANES; k++) begin : g_old
    assign lane_old[k] = los_q[k] >= LOS_CNT_W'(LOS_MIN_US * CLK_MHZ);
    // the timer never runs past its fail point
    AST_LOSCAP: assert property (@(posedge clk) disable iff (!rst_b)
      los_q[k] <= LOS_CNT_W'(LOS_FAIL_CYC))
      else $error("loss timer overran");
    // a valid lane restarts its timer
    AST_LOSCLR: assert property (@(posedge clk) disable iff (!rst_b)
      rx_valid[k] |=> los_q[k] == '0)
      else $error("loss timer not cleared");
    // a lost lane counts one per device clock
    AST_LOSRUN: assert property (@(posedge clk) disable iff (!rst_b)
      !rx_valid[k] && !lane_lost[k] |=> los_q[k] == $past(los_q[k]) + 1'b1)
      else $error("loss timer not counting");
  end
endmodule
`default_nettype wire

// ### testbench/cxl_far_end.sv
// Purpose: remote four-lane end seen through the twinax cable
// Assumes: one lane bit per device clock
// Notes: a lost lane shows noise that toggles, never a held value
`timescale 1ns/10ps
`default_nettype none
module cxl_far_end (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // stimulus from the bench
  input wire logic [3:0] data,
  input wire logic [3:0] lost,
  // lane side
  output logic [3:0] rx_lane,
  output logic [3:0] rx_valid
);
  logic [3:0] noise_q; // toggles so a lost lane never looks stable
  // free-running noise source
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      noise_q <= 4'h5;
    end else begin
      noise_q <= ~noise_q;
    end
  end
  assign rx_lane = (data & ~lost) | (noise_q & lost);
  assign rx_valid = ~lost;
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Purpose: self-checking bench for the lane control block
// Assumes: zero-wait apb slave, one-cycle lane pipeline
// Notes: detect timeout is a package constant, so the run is long
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
  import cxl_pkg::*;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, perr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, signal_detect, fault, tx_fault, rx_fault, irq;
  logic [3:0] tx_bit = 4'h0, rx_bit, tx_lane, rx_lane, rx_valid;
  logic [3:0] fd = 4'h0, lost = 4'hF;
  cxl_fault_s fault_in = '0;
  int num_errors = 0, total_checks = 0;
  cxl_lane_ctrl dut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_bit(tx_bit),
    .rx_bit(rx_bit), .tx_lane(tx_lane), .rx_lane(rx_lane),
    .rx_valid(rx_valid), .fault_in(fault_in), .signal_detect(signal_detect),
    .fault(fault), .tx_fault(tx_fault), .rx_fault(rx_fault), .irq(irq));
  cxl_far_end far (.clk(clk), .rst_b(rst_b), .data(fd), .lost(lost),
    .rx_lane(rx_lane), .rx_valid(rx_valid));
  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // let n edges pass, then look once values settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    `CHK(signal_detect, 1'b0)
    `CHK(tx_lane, 4'h0)
    `CHK(pready, 1'b1)
    apb(0, REG_CTRL, 0);
    `CHK(rd[7:0], CTRL_RST)
    apb(0, REG_MASK, 0);
    `CHK(rd[3:0], MASK_RST)
    apb(1, 8'h40, 32'hFF);
    `CHK(perr, 1'b1)
    apb(0, REG_CTRL, 0);
    `CHK(rd[7:0], CTRL_RST) // unmapped write left control alone
  endtask
  // walking one through both directions, no inversion
  task automatic t_map;
    for (int i = 0; i < 4; i++) begin
      tx_bit <= 4'h1 << i;
      fd <= 4'h8 >> i;
      lost <= 4'h0;
      tick(1);
      `CHK(tx_lane, 4'h1 << i)
      `CHK(rx_bit, 4'h8 >> i)
    end
  endtask
  task automatic t_dis;
    tx_bit <= 4'hF;
    apb(1, REG_CTRL, 32'h07);
    tick(2);
    `CHK(tx_lane, 4'h0)
    `CHK(rx_bit, 4'hF)
    apb(1, REG_CTRL, 32'h26);
    tick(2);
    `CHK(tx_lane, 4'hD)
    `CHK(rx_bit, 4'hF)
    apb(1, REG_CTRL, 32'h04);
  endtask
  task automatic t_fault;
    fault_in <= '{4'h2, 4'h0};
    tick(2);
    `CHK({fault, tx_fault, rx_fault}, 3'b110)
    `CHK(tx_lane, 4'h0)
    `CHK(irq, 1'b0)
    apb(0, REG_STAT, 0);
    `CHK(rd[7:0], 8'hF7)
    fault_in <= '{4'h0, 4'h8};
    tick(1);
    `CHK({fault, tx_fault, rx_fault}, 3'b101)
    apb(1, REG_MASK, 32'h4);
    tick(1);
    `CHK(irq, 1'b1)
    fault_in <= '0;
    apb(1, REG_IRQ, 32'h4);
    tick(1);
    `CHK(irq, 1'b0)
    `CHK(fault, 1'b0)
  endtask
  // qualify, then lose one lane and time the fall
  task automatic t_detect;
    int n;
    lost <= 4'h0;
    tick(2);
    `CHK(signal_detect, 1'b1)
    lost <= 4'h4;
    tick(62400);
    `CHK(signal_detect, 1'b1)
    n = 0;
    while (signal_detect === 1'b1 && n < 62600) begin
      tick(1);
      n++;
    end
    `CHK(signal_detect, 1'b0)
    apb(0, REG_IRQ, 0);
    `CHK(rd[3:0], 4'hB)
    apb(1, REG_IRQ, 32'hF);
    apb(0, REG_IRQ, 0);
    `CHK(rd[3:0], 4'h0)
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    tick(10);
    rst_b <= 1;
    tick(1);
    t_reset();
    t_map();
    t_dis();
    t_fault();
    t_detect();
    tally_and_finish();
  end
  // watchdog against a hang
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
